// ==== bench/ipgc_checker.sv ====
// Concurrent checks of the image port control block, seen from its ports.
// Assumes the control registers can be shadowed from completed APB writes.
`timescale 1ns/1ns
module ipgc_checker
	import ipgc_pkg::*;
#(
	parameter int FILL_W = 6
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Port side
	input wire logic [FILL_W-1:0] fifoFill,
	input wire logic portClockSrc,
	input wire logic dataQualifierSrc,
	input wire logic gatedClockMode,
	input wire logic auxPortClocks,
	input wire logic almostEmptyFlag,
	input wire logic almostFullFlag,
	input wire logic portClockOut,
	input wire logic dataQualifierOut,
	input wire logic portOutEnable,
	input wire ipgc_power_t powerCtrl
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [7:0] lvl_q;
	logic [7:0] ph_q;
	logic [7:0] pwr_q;
	// Address decode and expected values from the shadows
	wire isLvl = paddr == IPGC_ADDR_FLAG_LEVELS;
	wire isPh = paddr == IPGC_ADDR_PHASE_ENABLE;
	wire isPwr = paddr == IPGC_ADDR_POWER_SAVE;
	wire isSt = paddr == IPGC_ADDR_STATUS;
	wire apbWr = psel & penable & pwrite & pstrb[0] & pready;
	wire [5:0] fill6 = 6'(fifoFill);
	wire [5:0] eLim = lvl_q[1] ? (lvl_q[0] ? 6'h01 : 6'h04) : (lvl_q[0] ? 6'h08 : 6'h10);
	wire [5:0] fLim = lvl_q[3] ? (lvl_q[2] ? 6'h20 : 6'h1c) : (lvl_q[2] ? 6'h18 : 6'h10);
	wire [1:0] gqSel = gatedClockMode ? ph_q[7:6] : 2'h0;
	// Scaler runs when awake, and with the decoder asleep only on auxiliary clocks
	wire scAct = !pwr_q[1] && (!pwr_q[0] || auxPortClocks);
	wire clkSrcEff = portClockSrc && scAct;
	wire qualSrcEff = dataQualifierSrc && scAct;
	wire [5:0] pwrExp = {pwr_q[6], pwr_q[7], !pwr_q[0], scAct, !pwr_q[3], pwr_q[5]};
	wire [7:0] rdExp = isLvl ? lvl_q : (isPh ? ph_q : pwr_q);
	// Shadows keep only the implemented bits, so readback checks the masks too
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lvl_q <= 8'h00;
			ph_q <= 8'h00;
			pwr_q <= 8'h00;
		end else if (apbWr) begin
			if (isLvl) lvl_q <= {4'h0, pwdata[3:0]};
			if (isPh) ph_q <= {pwdata[7:4], 2'h0, pwdata[1:0]};
			if (isPwr) pwr_q <= {pwdata[7:3], 1'h0, pwdata[1:0]};
		end
	end
	function automatic logic phExp(logic [1:0] s, logic a, logic b);
		return s[0] ^ (s[1] ? b : a);
	endfunction
	// Two quiet cycles after reset and a steady selection
	sequence s_settled;
		!$past(rst) && !$past(rst, 2) && $past(ph_q) == $past(ph_q, 2) && $past(gatedClockMode) == $past(gatedClockMode, 2);
	endsequence
	a_empty_flag: assert property (
		!$past(rst) |-> almostEmptyFlag == $past(fill6 < eLim)) else $error("almost empty flag wrong");
	a_full_flag: assert property (
		!$past(rst) |-> almostFullFlag == $past(fill6 >= fLim)) else $error("almost full flag wrong");
	a_clock_phase: assert property (
		s_settled |-> portClockOut == phExp($past(ph_q[5:4]), $past(clkSrcEff), $past(clkSrcEff, 2)))
		else $error("port clock phase wrong");
	a_gated_phase: assert property (
		s_settled |-> dataQualifierOut == phExp($past(gqSel), $past(qualSrcEff), $past(qualSrcEff, 2)))
		else $error("qualifier phase wrong");
	a_power_map: assert property (
		!$past(rst) |-> powerCtrl == $past(pwrExp)) else $error("power controls wrong");
	a_oe_blocked: assert property (
		!$past(rst) && ($past(ph_q[1:0]) == 2'h0 || $past(pwr_q[1])) |-> !portOutEnable) else $error("output enabled wrongly");
	a_reg_readback: assert property (
		psel && penable && !pwrite && (isLvl || isPh || isPwr) |-> prdata == {24'h0, rdExp}) else $error("readback wrong");
	a_access_error: assert property (
		psel && penable |-> pslverr == (!(isLvl || isPh || isPwr || isSt) || (pwrite && isSt))) else $error("error response wrong");
endmodule

// ==== bench/ipgc_host_model.sv ====
// Host capture side stand-in: the FIFO fill count moves one double word
// per cycle toward a level the bench asks for, as a real FIFO cannot jump.
// Assumes the fill count is counted on ref_clk, as the block expects.
`timescale 1ns/1ns
module ipgc_host_model #(
	parameter int FILL_W = 6
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Requested level
	input wire logic [FILL_W-1:0] target,
	// Toward the block
	output logic [FILL_W-1:0] fifoFill
);
	// Fill or drain one step per cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fifoFill <= '0;
		end else if (fifoFill < target) begin
			fifoFill <= fifoFill + 1'h1;
		end else if (fifoFill > target) begin
			fifoFill <= fifoFill - 1'h1;
		end
	end
endmodule

// ==== bench/ipgc_top_bench.sv ====
// Self-checking bench of the image port control block with a host model.
// Assumes zero-wait APB answers are still awaited through pready.
`timescale 1ns/1ns
module ipgc_top_bench
	import ipgc_pkg::*;
;
	logic ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic portClockSrc = 1'h0, dataQualifierSrc = 1'h0, gatedClockMode = 1'h0;
	logic auxPortClocks = 1'h0, tristateCtrlPin = 1'h0, errSeen;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdVal;
	logic [3:0] pstrb = 4'hf;
	logic [5:0] target = 6'h00, fifoFill;
	logic pready, pslverr, almostEmptyFlag, almostFullFlag, portClockOut, dataQualifierOut, portOutEnable;
	ipgc_power_t powerCtrl;
	int n_mismatch = 0, checked = 0, cyc = 0;
	ipgc_top #(.FILL_W(6)) dut_u (.*);
	ipgc_host_model #(.FILL_W(6)) host_u (.ref_clk, .rst, .target, .fifoFill);
	always #50 ref_clk = ~ref_clk;
	// Busy port sources and a timeout well beyond the several hundred cycles needed
	always @(posedge ref_clk) begin
		portClockSrc <= ~portClockSrc;
		dataQualifierSrc <= cyc[1];
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// One APB transfer; held until pready is seen high at an edge
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rdVal = prdata;
		errSeen = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic t_reset_vals();
		check("empty at reset", almostEmptyFlag, 1'h1);
		check("power at reset", powerCtrl, 6'h0e);
		apb(1'h0, IPGC_ADDR_POWER_SAVE, 32'h0);
		check("marker at reset", rdVal, 32'h0);
	endtask
	task automatic t_fifo_flags();
		int eL[4] = '{16, 8, 4, 1};
		int fL[4] = '{16, 24, 28, 32};
		int fills[14] = '{0, 1, 3, 4, 7, 8, 15, 16, 23, 24, 27, 28, 31, 32};
		for (int s = 0; s < 4; s++) begin
			apb(1'h1, IPGC_ADDR_FLAG_LEVELS, {24'h0, 4'hf, 2'(s), 2'(s)});
			apb(1'h0, IPGC_ADDR_FLAG_LEVELS, 32'h0);
			check("level readback", rdVal, {28'h0, 2'(s), 2'(s)});
			foreach (fills[i]) begin
				@(posedge ref_clk);
				target <= 6'(fills[i]);
				for (int k = 0; k < 40 && fifoFill !== 6'(fills[i]); k++) tick(1);
				tick(2);
				check("almost empty", almostEmptyFlag, fills[i] < eL[s]);
				check("almost full", almostFullFlag, fills[i] >= fL[s]);
			end
		end
	endtask
	task automatic t_phase();
		for (int g = 0; g < 2; g++) begin
			@(posedge ref_clk);
			gatedClockMode <= 1'(g);
			for (int c = 0; c < 4; c++) begin
				apb(1'h1, IPGC_ADDR_PHASE_ENABLE, {24'h0, 2'(c), 2'(3 - c), 4'hd});
				tick(6);
				apb(1'h0, IPGC_ADDR_PHASE_ENABLE, 32'h0);
				check("phase readback", rdVal, {24'h0, 2'(c), 2'(3 - c), 4'h1});
			end
		end
		// half cycle shift as advised for the divided clock source
		apb(1'h1, IPGC_ADDR_PHASE_ENABLE, 32'h51);
		tick(6);
		apb(1'h0, IPGC_ADDR_PHASE_ENABLE, 32'h0);
		check("advised phase", rdVal, 32'h51);
	endtask
	task automatic t_out_enable();
		logic e;
		for (int m = 0; m < 4; m++) begin
			for (int p = 0; p < 2; p++) begin
				@(posedge ref_clk);
				tristateCtrlPin <= 1'(p);
				apb(1'h1, IPGC_ADDR_PHASE_ENABLE, 32'(m));
				tick(6);
				e = (m == 1) || (m == 2 && p == 0) || (m == 3 && p == 1);
				check("output enable", portOutEnable, e);
			end
		end
		apb(1'h1, IPGC_ADDR_PHASE_ENABLE, 32'h1);
		apb(1'h1, IPGC_ADDR_POWER_SAVE, 32'h2);
		tick(3);
		check("enable scaler asleep", portOutEnable, 1'h0);
		apb(1'h1, IPGC_ADDR_POWER_SAVE, 32'h1);
		tick(3);
		check("enable decoder asleep", portOutEnable, 1'h0);
		@(posedge ref_clk);
		auxPortClocks <= 1'h1;
		tick(4);
		check("enable aux clocks", portOutEnable, 1'h1);
	endtask
	task automatic t_power();
		logic [7:0] vals[4] = '{8'hff, 8'h00, 8'h5a, 8'ha5};
		foreach (vals[i]) begin
			apb(1'h1, IPGC_ADDR_POWER_SAVE, {24'h0, vals[i]});
			tick(3);
			check("power map", powerCtrl, {vals[i][6], vals[i][7], !vals[i][0],
				!vals[i][1] && (!vals[i][0] || auxPortClocks), !vals[i][3], vals[i][5]});
			apb(1'h0, IPGC_ADDR_POWER_SAVE, 32'h0);
			check("power readback", rdVal, {24'h0, vals[i] & 8'hfb});
			apb(1'h0, IPGC_ADDR_STATUS, 32'h0);
			check("marker copy", rdVal[3], vals[i][4]);
		end
		apb(1'h0, 12'h000, 32'h0);
		check("unmapped read error", errSeen, 1'h1);
		check("unmapped read data", rdVal, 32'h0);
		apb(1'h1, IPGC_ADDR_STATUS, 32'hff);
		check("status write refused", errSeen, 1'h1);
		rst <= 1'h1;
		tick(2);
		@(posedge ref_clk);
		rst <= 1'h0;
		apb(1'h0, IPGC_ADDR_POWER_SAVE, 32'h0);
		check("marker after reset", rdVal, 32'h0);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'h0;
		tick(2);
		t_reset_vals();
		t_fifo_flags();
		t_phase();
		t_out_enable();
		t_power();
		test_done();
	end
endmodule
bind ipgc_top ipgc_checker #(.FILL_W(FILL_W)) chk_u (.*);

// ==== design/ipgc_phase_gen.sv ====
// Phase shifter for one port clock style output.
// Assumes a single reference clock; the half-cycle shift is a falling-edge
// equivalent made by inverting, the short delay is one reference cycle.
`timescale 1ns/1ns
module ipgc_phase_gen
	import ipgc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Source and selection
	input wire logic srcIn,
	input wire ipgc_phase_t phaseSel,
	// Shifted output
	output logic phaseOut
);

	logic [IPGC_PHASE_DELAY_CYC-1:0] dlyQ;
	logic [IPGC_PHASE_DELAY_CYC:0] dlyNext;
	logic dlyTap;
	logic phaseD;
	logic phaseQ;

	// Delay line stands in for the analog delay cell; coarse at 10 MHz
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dlyQ <= '0;
		end else begin
			dlyQ <= dlyNext[IPGC_PHASE_DELAY_CYC-1:0];
		end
	end

	// Shift in the source; the oldest sample drops off the top
	assign dlyNext = {dlyQ, srcIn};

	assign dlyTap = dlyQ[IPGC_PHASE_DELAY_CYC-1];

	always_comb begin
		case (phaseSel)
			IPGC_PH_DEFAULT: phaseD = srcIn;
			IPGC_PH_HALF: phaseD = ~srcIn;
			IPGC_PH_DELAY: phaseD = dlyTap;
			IPGC_PH_HALF_DELAY: phaseD = ~dlyTap;
			default: phaseD = srcIn;
		endcase
	end

	// Registered so the output is a clean data output
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phaseQ <= 1'b0;
		end else begin
			phaseQ <= phaseD;
		end
	end

	assign phaseOut = phaseQ;

endmodule

// ==== design/ipgc_pkg.sv ====
// Package for the image port global control block: register map, field
// positions, reset values and the carrier structs shared by the design.
// Assumes a 32-bit APB master and a 10 MHz reference clock.
package ipgc_pkg;

	// Register byte addresses (printed offsets are not all multiples of four,
	// so each is an index and the byte address is four times it)
	localparam logic [7:0] IPGC_IDX_FLAG_LEVELS = 8'h86;
	localparam logic [7:0] IPGC_IDX_PHASE_ENABLE = 8'h87;
	localparam logic [7:0] IPGC_IDX_POWER_SAVE = 8'h88;
	localparam logic [7:0] IPGC_IDX_STATUS = 8'h8f;
	localparam logic [11:0] IPGC_ADDR_FLAG_LEVELS = {2'h0, IPGC_IDX_FLAG_LEVELS, 2'h0};
	localparam logic [11:0] IPGC_ADDR_PHASE_ENABLE = {2'h0, IPGC_IDX_PHASE_ENABLE, 2'h0};
	localparam logic [11:0] IPGC_ADDR_POWER_SAVE = {2'h0, IPGC_IDX_POWER_SAVE, 2'h0};
	localparam logic [11:0] IPGC_ADDR_STATUS = {2'h0, IPGC_IDX_STATUS, 2'h0};

	// Field positions, flag level register
	localparam int IPGC_EMPTY_LSB = 0;
	localparam int IPGC_FULL_LSB = 2;
	// Field positions, phase and enable register
	localparam int IPGC_OE_LSB = 0;
	localparam int IPGC_CKPH_LSB = 4;
	localparam int IPGC_GQPH_LSB = 6;
	// Field positions, power save register
	localparam int IPGC_DECSLP_BIT = 0;
	localparam int IPGC_SCLSLP_BIT = 1;
	localparam int IPGC_AUDSLP_BIT = 3;
	localparam int IPGC_MARK_BIT = 4;
	localparam int IPGC_SCALER_SOFT_RESET_BIT = 5;
	localparam int IPGC_CH1EN_BIT = 6;
	localparam int IPGC_FIRST_CHANNEL_ENABLE_BIT = 7;
	// Field position, status register
	localparam int IPGC_MARKCOPY_BIT = 3;

	// Reset values
	localparam logic [7:0] IPGC_RST_FLAG_LEVELS = 8'h00;
	localparam logic [7:0] IPGC_RST_PHASE_ENABLE = 8'h00;
	localparam logic [7:0] IPGC_RST_POWER_SAVE = 8'h00;

	// FIFO thresholds in double words
	localparam logic [5:0] IPGC_LVL_0 = 6'h00;
	localparam logic [5:0] IPGC_LVL_4 = 6'h04;
	localparam logic [5:0] IPGC_LVL_8 = 6'h08;
	localparam logic [5:0] IPGC_LVL_16 = 6'h10;
	localparam logic [5:0] IPGC_LVL_24 = 6'h18;
	localparam logic [5:0] IPGC_LVL_28 = 6'h1c;
	localparam logic [5:0] IPGC_LVL_32 = 6'h20;

	// Phase timing: half cycle plus a fixed delay of about 3 ns
	localparam int IPGC_REF_CLK_HZ = 10000000;
	localparam int IPGC_PHASE_DELAY_NS = 3;
	localparam int IPGC_PHASE_DELAY_CYC = ((IPGC_PHASE_DELAY_NS * (IPGC_REF_CLK_HZ / 1000000)) + 999) / 1000;

	// Phase selection codes
	typedef enum logic [1:0] {
		IPGC_PH_DEFAULT = 2'h0,
		IPGC_PH_HALF = 2'h1,
		IPGC_PH_DELAY = 2'h2,
		IPGC_PH_HALF_DELAY = 2'h3
	} ipgc_phase_t;

	// Output enable source codes
	typedef enum logic [1:0] {
		IPGC_OE_OFF = 2'h0,
		IPGC_OE_ON = 2'h1,
		IPGC_OE_PIN_LOW = 2'h2,
		IPGC_OE_PIN_HIGH = 2'h3
	} ipgc_oe_t;

	// Decoded power controls toward the rest of the chip
	typedef struct packed {
		logic firstChannelOn;
		logic secondChannelOn;
		logic decoderOn;
		logic scalerOn;
		logic audioClockOn;
		logic scalerRunRst;
	} ipgc_power_t;

endpackage

// ==== design/ipgc_top.sv ====
// Global control registers of the image output port and power management.
// Assumes an APB master on ref_clk, a FIFO fill count from port logic on the
// same clock, and the tristate pin arriving asynchronously from outside.
`timescale 1ns/1ns

module ipgc_top
	import ipgc_pkg::*;
#(
	parameter int FILL_W = 6
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port FIFO and clock inputs
	input wire logic [FILL_W-1:0] fifoFill,
	input wire logic portClockSrc,
	input wire logic dataQualifierSrc,
	input wire logic gatedClockMode,
	input wire logic auxPortClocks,
	input wire logic tristateCtrlPin,
	// Port outputs
	output logic almostEmptyFlag,
	output logic almostFullFlag,
	output logic portClockOut,
	output logic dataQualifierOut,
	output logic portOutEnable,
	// Power controls
	output ipgc_power_t powerCtrl
);

	logic [7:0] flagLevelsQ;
	logic [7:0] phaseEnableQ;
	logic [7:0] powerSaveQ;
	logic triSync1Q;
	logic triSync2Q;
	logic aeQ;
	logic afQ;
	logic oeQ;
	logic [31:0] rdataQ;
	ipgc_power_t powerQ;

	// APB decode; the slave always answers in the first access cycle
	wire apbAccess = psel & penable;
	wire apbWrite = apbAccess & pwrite & pstrb[0];
	wire selFlag = (paddr == IPGC_ADDR_FLAG_LEVELS);
	wire selPhase = (paddr == IPGC_ADDR_PHASE_ENABLE);
	wire selPower = (paddr == IPGC_ADDR_POWER_SAVE);
	wire selStatus = (paddr == IPGC_ADDR_STATUS);
	wire selAny = selFlag | selPhase | selPower | selStatus;
	wire wrFlag = apbWrite & selFlag;
	wire wrPhase = apbWrite & selPhase;
	wire wrPower = apbWrite & selPower;
	// Status is read only, so a write there is an error like an unmapped one
	wire badAccess = ~selAny | (pwrite & selStatus);

	assign pready = 1'b1;
	assign pslverr = apbAccess & badAccess;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flagLevelsQ <= IPGC_RST_FLAG_LEVELS;
			phaseEnableQ <= IPGC_RST_PHASE_ENABLE;
		end else begin
			if (wrFlag) begin
				flagLevelsQ <= {4'h0, pwdata[3:0]};
			end
			if (wrPhase) begin
				phaseEnableQ <= {pwdata[7:4], 2'h0, pwdata[1:0]};
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			powerSaveQ <= IPGC_RST_POWER_SAVE;
		end else if (wrPower) begin
			powerSaveQ <= {pwdata[7:3], 1'b0, pwdata[1:0]};
		end
	end

	// Field views
	wire [1:0] emptySel = flagLevelsQ[IPGC_EMPTY_LSB +: 2];
	wire [1:0] fullSel = flagLevelsQ[IPGC_FULL_LSB +: 2];
	wire [1:0] oeSel = phaseEnableQ[IPGC_OE_LSB +: 2];
	wire [1:0] clkPhSel = phaseEnableQ[IPGC_CKPH_LSB +: 2];
	wire [1:0] gatedPhSel = phaseEnableQ[IPGC_GQPH_LSB +: 2];
	wire decoderSleep = powerSaveQ[IPGC_DECSLP_BIT];
	wire scalerSleep = powerSaveQ[IPGC_SCLSLP_BIT];
	wire audioClockSleep = powerSaveQ[IPGC_AUDSLP_BIT];
	wire programmedMarker = powerSaveQ[IPGC_MARK_BIT];
	wire scalerSoftReset = powerSaveQ[IPGC_SCALER_SOFT_RESET_BIT];
	wire firstChannelEnable = powerSaveQ[IPGC_CH1EN_BIT];
	wire secondChannelEnable = powerSaveQ[IPGC_FIRST_CHANNEL_ENABLE_BIT];

	// Fill count widened to the threshold width before compare
	wire [5:0] fill6 = 6'(fifoFill);

	wire emptyD = (emptySel == 2'h0) ? (fill6 < IPGC_LVL_16) :
		(emptySel == 2'h1) ? (fill6 < IPGC_LVL_8) :
		(emptySel == 2'h2) ? (fill6 < IPGC_LVL_4) :
		(fill6 == IPGC_LVL_0);
	wire fullD = (fullSel == 2'h0) ? (fill6 >= IPGC_LVL_16) :
		(fullSel == 2'h1) ? (fill6 >= IPGC_LVL_24) :
		(fullSel == 2'h2) ? (fill6 >= IPGC_LVL_28) :
		(fill6 >= IPGC_LVL_32);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aeQ <= 1'b1;
			afQ <= 1'b0;
		end else begin
			aeQ <= emptyD;
			afQ <= fullD;
		end
	end

	assign almostEmptyFlag = aeQ;
	assign almostFullFlag = afQ;

	// Tristate pin is asynchronous; only the second stage is read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			triSync1Q <= 1'b0;
			triSync2Q <= 1'b0;
		end else begin
			triSync1Q <= tristateCtrlPin;
			triSync2Q <= triSync1Q;
		end
	end

	// scaler runs with decoder asleep only on auxiliary port clocks
	wire scalerPathOk = ~decoderSleep | auxPortClocks;
	wire scalerActive = ~scalerSleep & scalerPathOk;

	wire oeD = (oeSel == IPGC_OE_ON) ? 1'b1 :
		(oeSel == IPGC_OE_PIN_LOW) ? ~triSync2Q :
		(oeSel == IPGC_OE_PIN_HIGH) ? triSync2Q :
		1'b0;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oeQ <= 1'b0;
		end else begin
			oeQ <= oeD & scalerActive;
		end
	end

	assign portOutEnable = oeQ;

	// gated phase only in gated mode
	wire [1:0] gatedPhEff = gatedClockMode ? gatedPhSel : 2'h0;

	ipgc_phase_gen uClkPhase (
		.ref_clk(ref_clk),
		.rst(rst),
		.srcIn(portClockSrc & scalerActive),
		.phaseSel(ipgc_phase_t'(clkPhSel)),
		.phaseOut(portClockOut)
	);

	ipgc_phase_gen uQualPhase (
		.ref_clk(ref_clk),
		.rst(rst),
		.srcIn(dataQualifierSrc & scalerActive),
		.phaseSel(ipgc_phase_t'(gatedPhEff)),
		.phaseOut(dataQualifierOut)
	);

	// Power control decode, registered for clean outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			powerQ <= '0;
		end else begin
			powerQ.firstChannelOn <= firstChannelEnable;
			powerQ.secondChannelOn <= secondChannelEnable;
			powerQ.decoderOn <= ~decoderSleep;
			powerQ.scalerOn <= scalerActive;
			powerQ.audioClockOn <= ~audioClockSleep;
			powerQ.scalerRunRst <= scalerSoftReset;
		end
	end

	assign powerCtrl = powerQ;

	// Read mux; marker mirrored into status
	wire [7:0] statusByte = {1'b0, triSync2Q, afQ, 1'b0, programmedMarker, 3'h0};
	wire [7:0] rdByte = selFlag ? flagLevelsQ :
		selPhase ? phaseEnableQ :
		selPower ? powerSaveQ :
		selStatus ? statusByte :
		8'h00;

	// Read data registered at the setup cycle so it is stable in access
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdataQ <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			rdataQ <= {24'h000000, rdByte};
		end
	end

	assign prdata = rdataQ;

endmodule
